// >>> src/txc_device.sv
// Functional notes
// - calibration starts on start bit rising edge
// - host clears start bit after calibration
// - dual bit stores result in both slots
// - wait bit selects full or half wait
// - wait scales with reference, 14 ms
// - current bit doubles calibration current
// - read-only done bit, reset zero
// - host programs DAC start value 110
// - symbol rate field selects eight rates
// - line coding NRZ, Manchester, UART passthrough
// - host sets crystal range to fitted crystal
// - active-low bit holds synthesizer in reset
// - swing field scales prescaler swing
// - current field scales prescaler current
// - bypass bit shorts loop filter resistor
// - capacitor disconnect only for fast rates; host clears it on divider writes made at slow rates
`timescale 1ns/1ns
`include "txc_consts.svh"
module txc_device
  import txc_pkg::*;
#(
  parameter int unsigned CAL_WAIT_TICKS = `TXC_CAL_WAIT_TICKS
) (
  input  wire logic   clk,
  input  wire logic   arst_n,
  txc_if.device       lnk,
  input  wire logic   ref_tick,
  input  wire logic   slot_b_select,
  output logic [2:0]  symbol_rate_select,
  output logic [9:0]  symbol_rate_hbaud,
  output logic [1:0]  line_coding,
  output logic [1:0]  crystal_range_select,
  output logic        synth_hold_low,
  output logic [1:0]  pre_swing,
  output logic [1:0]  pre_current,
  output logic        loop_r_bypass,
  output logic        loop_c_disconnect,
  output logic [2:0]  calib_dac_start_value,
  output logic        cal_active,
  output logic        cal_current_double,
  output logic        cal_store_a,
  output logic        cal_store_b
);
  txc_dev_state_type s_reg;
  txc_dev_state_type s_next;
  logic              cal_go;
  logic              tmr_busy;
  logic              tmr_done;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    return a == ofs;
  endfunction

  // unused bits are dropped on write so they read back as zero
  function automatic logic [7:0] keep(input logic [7:0] d, input logic [7:0] mask);
    return d & mask;
  endfunction

  // unmapped offsets read as zero
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input txc_dev_state_type v);
    logic [7:0] d;
    d = 8'h00;
    if (hit(a, `TXC_OFS_CAL)) begin
      d = v.cal;
    end else if (hit(a, `TXC_OFS_MODEM)) begin
      d = v.modem;
    end else if (hit(a, `TXC_OFS_SYNTH)) begin
      d = v.synth;
    end else if (hit(a, `TXC_OFS_DIVF)) begin
      d = v.divf;
    end
    return d;
  endfunction

  // symbol rate in units of 100 baud
  function automatic logic [9:0] rate_of(input logic [2:0] code);
    logic [9:0] r;
    case (code)
      3'h0:    r = 10'h006;
      3'h1:    r = 10'h00c;
      3'h2:    r = 10'h018;
      3'h3:    r = 10'h030;
      3'h4:    r = 10'h060;
      3'h5:    r = 10'h0c0;
      3'h6:    r = 10'h180;
      default: r = 10'h300;
    endcase
    return r;
  endfunction

  // the wait bit comes from the launching write itself
  txc_cal_timer #(
    .TICKS (CAL_WAIT_TICKS)
  ) u_timer (
    .clk      (clk),
    .arst_n   (arst_n),
    .start    (cal_go),
    .half     (~lnk.wdata[`TXC_CAL_WAIT]),
    .ref_tick (ref_tick),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  always_comb begin
    s_next          = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.store_a  = 1'b0;
    s_next.store_b  = 1'b0;
    cal_go          = 1'b0;

    if (lnk.wr_en) begin
      if (hit(lnk.addr, `TXC_OFS_CAL)) begin
        // only a 0 to 1 change launches; holding the bit at 1 does nothing
        cal_go = lnk.wdata[`TXC_CAL_START] & ~s_reg.cal[`TXC_CAL_START];
        // done bit is not writable
        s_next.cal = {lnk.wdata[7:4], s_reg.cal[`TXC_CAL_DONE], lnk.wdata[2:0]};
        if (cal_go) begin
          s_next.cal[`TXC_CAL_DONE] = 1'b0;
        end
      end
      if (hit(lnk.addr, `TXC_OFS_MODEM)) begin
        s_next.modem = keep(lnk.wdata, `TXC_MASK_MODEM);
      end
      if (hit(lnk.addr, `TXC_OFS_SYNTH)) begin
        s_next.synth = keep(lnk.wdata, `TXC_MASK_SYNTH);
      end
      if (hit(lnk.addr, `TXC_OFS_DIVF)) begin
        s_next.divf = keep(lnk.wdata, `TXC_MASK_DIVF);
      end
    end

    if (lnk.rd_en) begin
      s_next.rd_valid = 1'b1;
      s_next.rdata    = rd_mux(lnk.addr, s_reg);
    end

    case (s_reg.st)
      CAL_IDLE: begin
        if (cal_go) begin
          s_next.st = CAL_RUN;
        end
      end
      CAL_RUN: begin
        // a new launch restarts the timer, so its old done is dropped
        if (!cal_go && tmr_done) begin
          s_next.st                 = CAL_IDLE;
          s_next.cal[`TXC_CAL_DONE] = 1'b1;
          // slot select is sampled at completion, not at launch
          s_next.store_a = s_reg.cal[`TXC_CAL_DUAL] | ~slot_b_select;
          s_next.store_b = s_reg.cal[`TXC_CAL_DUAL] | slot_b_select;
        end
      end
      default: begin
        s_next.st = CAL_IDLE;
      end
    endcase

    // from the next state so the doubled current starts with the run
    s_next.cur_double = (s_next.st == CAL_RUN) & s_next.cal[`TXC_CAL_CURR];
    // decoded ahead so the output leaves a flop
    s_next.rate_hbaud = rate_of(s_next.modem[`TXC_RATE_MSB:`TXC_RATE_LSB]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{
        st:         CAL_IDLE,
        cal:        `TXC_RST_CAL,
        modem:      `TXC_RST_MODEM,
        synth:      `TXC_RST_SYNTH,
        divf:       `TXC_RST_DIVF,
        rdata:      8'h00,
        rd_valid:   1'b0,
        store_a:    1'b0,
        store_b:    1'b0,
        cur_double: 1'b0,
        rate_hbaud: 10'h018
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.rdata             = s_reg.rdata;
  assign lnk.rd_valid          = s_reg.rd_valid;
  assign lnk.cal_complete      = s_reg.cal[`TXC_CAL_DONE];

  assign symbol_rate_select    = s_reg.modem[`TXC_RATE_MSB:`TXC_RATE_LSB];
  assign symbol_rate_hbaud     = s_reg.rate_hbaud;
  assign line_coding           = s_reg.modem[`TXC_CODE_MSB:`TXC_CODE_LSB];
  assign crystal_range_select  = s_reg.modem[`TXC_XTAL_MSB:`TXC_XTAL_LSB];
  // only a level out; calibration does not wait on it
  assign synth_hold_low        = s_reg.synth[0];
  assign pre_swing             = s_reg.divf[`TXC_SWING_MSB:`TXC_SWING_LSB];
  assign pre_current           = s_reg.divf[`TXC_PCUR_MSB:`TXC_PCUR_LSB];
  assign loop_r_bypass         = s_reg.divf[`TXC_BYP_R];
  assign loop_c_disconnect     = s_reg.divf[`TXC_DISC_C];
  assign calib_dac_start_value = s_reg.cal[2:0];
  assign cal_active            = s_reg.st == CAL_RUN;
  assign cal_current_double    = s_reg.cur_double;
  assign cal_store_a           = s_reg.store_a;
  assign cal_store_b           = s_reg.store_b;

  // the timer's busy flag rises with the run state but drops one cycle before it ends; kept for visibility only
  logic unused_busy;
  assign unused_busy = tmr_busy;
endmodule // txc_device

// >>> src/txc_consts.svh
`ifndef TXC_CONSTS_SVH
`define TXC_CONSTS_SVH

// device register offsets
`define TXC_OFS_CAL     7'h0e
`define TXC_OFS_MODEM   7'h11
`define TXC_OFS_SYNTH   7'h13
`define TXC_OFS_DIVF    7'h1c

// reset values
`define TXC_RST_CAL     8'h05
`define TXC_RST_MODEM   8'h24
`define TXC_RST_SYNTH   8'h01
`define TXC_RST_DIVF    8'h00

// writable bits; the rest read as zero
`define TXC_MASK_MODEM  8'h7f
`define TXC_MASK_SYNTH  8'h01
`define TXC_MASK_DIVF   8'hfc

// calibration_control fields
`define TXC_CAL_START   7
`define TXC_CAL_DUAL    6
`define TXC_CAL_WAIT    5
`define TXC_CAL_CURR    4
`define TXC_CAL_DONE    3
`define TXC_ITER_NORMAL 3'h6

// modem_setup fields
`define TXC_RATE_MSB    6
`define TXC_RATE_LSB    4
`define TXC_CODE_MSB    3
`define TXC_CODE_LSB    2
`define TXC_XTAL_MSB    1
`define TXC_XTAL_LSB    0
`define TXC_RATE_FAST   3'h6

// divider_front_tuning fields
`define TXC_SWING_MSB   7
`define TXC_SWING_LSB   6
`define TXC_PCUR_MSB    5
`define TXC_PCUR_LSB    4
`define TXC_BYP_R       3
`define TXC_DISC_C      2

// calibration wait: 14 ms at a 2 MHz reference, counted in reference ticks
`define TXC_CAL_WAIT_MS  14
`define TXC_CAL_REF_KHZ  2000
`define TXC_CAL_WAIT_TICKS (`TXC_CAL_WAIT_MS * `TXC_CAL_REF_KHZ)

// host apb map
`define TXC_HOST_CMD    12'h000
`define TXC_HOST_STAT   12'h004
`define TXC_HOST_IRQ    12'h008
`define TXC_HOST_MASK   12'h00c
`define TXC_CMD_READ    16
`define TXC_IRQ_XFER    0
`define TXC_IRQ_CAL     1

`endif

// >>> src/txc_pkg.sv
package txc_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } txc_cal_state_type;

  typedef enum logic [2:0] {
    LNK_IDLE = 3'b001,
    LNK_WR   = 3'b010,
    LNK_RD   = 3'b100
  } txc_link_state_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } txc_tmr_state_type;

  typedef struct packed {
    txc_cal_state_type st;
    logic [7:0]        cal;
    logic [7:0]        modem;
    logic [7:0]        synth;
    logic [7:0]        divf;
    logic [7:0]        rdata;
    logic              rd_valid;
    logic              store_a;
    logic              store_b;
    logic              cur_double;
    logic [9:0]        rate_hbaud;
  } txc_dev_state_type;

  typedef struct packed {
    txc_link_state_type st;
    logic              wr_en;
    logic              rd_en;
    logic [6:0]        addr;
    logic [7:0]        wdata;
    logic [7:0]        rd_last;
    logic [7:0]        cal_shadow;
    logic [7:0]        modem_shadow;
    logic              clr_pending;
    logic              done_seen;
    logic [1:0]        irq_sts;
    logic [1:0]        irq_mask;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } txc_host_state_type;

endpackage

// >>> src/txc_if.sv
`timescale 1ns/1ns
interface txc_if;
  logic       wr_en;
  logic       rd_en;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rd_valid;
  logic       cal_complete;

  modport device (
    input  wr_en, rd_en, addr, wdata,
    output rdata, rd_valid, cal_complete
  );
  modport host (
    output wr_en, rd_en, addr, wdata,
    input  rdata, rd_valid, cal_complete
  );
endinterface

// >>> src/txc_cal_timer.sv
`timescale 1ns/1ns
`include "txc_consts.svh"
module txc_cal_timer
  import txc_pkg::*;
#(
  parameter int unsigned TICKS = `TXC_CAL_WAIT_TICKS
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic half,
  input  wire logic ref_tick,
  output logic      busy,
  output logic      done
);
  txc_tmr_state_type s_reg;
  txc_tmr_state_type s_next;

  // counting reference ticks makes the wait follow the reference frequency
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.busy = 1'b1;
      s_next.cnt  = half ? 16'(TICKS / 2) : 16'(TICKS);
    end else if (s_reg.busy && ref_tick) begin
      if (s_reg.cnt <= 16'h0001) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.cnt  = 16'h0000;
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{cnt: 16'h0000, busy: 1'b0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.busy;
  assign done = s_reg.done;
endmodule // txc_cal_timer

// >>> src/txc_host.sv
`timescale 1ns/1ns
`include "txc_consts.svh"
module txc_host
  import txc_pkg::*;
#(
  parameter logic [1:0] CRYSTAL_RANGE = 2'h0
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  txc_if.host              lnk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  txc_host_state_type s_reg;
  txc_host_state_type s_next;
  logic               apb_wr;
  logic               cmd_go;
  logic [7:0]         fixed;
  logic [1:0]         sts_set;

  // host-side fix-ups applied to every write sent to the device
  function automatic logic [7:0] fix(input logic [6:0] a, input logic [7:0] d,
                                     input logic [7:0] modem);
    logic [7:0] r;
    r = d;
    if (a == `TXC_OFS_CAL) begin
      r[2:0] = `TXC_ITER_NORMAL;
    end
    if (a == `TXC_OFS_MODEM) begin
      r[`TXC_XTAL_MSB:`TXC_XTAL_LSB] = CRYSTAL_RANGE;
    end
    if (a == `TXC_OFS_DIVF && modem[`TXC_RATE_MSB:`TXC_RATE_LSB] < `TXC_RATE_FAST) begin
      r[`TXC_DISC_C] = 1'b0;
    end
    return r;
  endfunction

  always_comb begin
    s_next        = s_reg;
    s_next.wr_en  = 1'b0;
    s_next.rd_en  = 1'b0;
    sts_set       = 2'b00;
    apb_wr        = psel & penable & pwrite & s_reg.pready;
    cmd_go        = apb_wr && paddr == `TXC_HOST_CMD && s_reg.st == LNK_IDLE;
    fixed         = fix(pwdata[14:8], pwdata[7:0], s_reg.modem_shadow);

    s_next.done_seen = lnk.cal_complete;
    if (lnk.cal_complete && !s_reg.done_seen) begin
      sts_set[`TXC_IRQ_CAL] = 1'b1;
      if (s_reg.cal_shadow[`TXC_CAL_START]) begin
        s_next.clr_pending = 1'b1;
      end
    end

    case (s_reg.st)
      LNK_IDLE: begin
        if (cmd_go) begin
          s_next.addr = pwdata[14:8];
          if (pwdata[`TXC_CMD_READ]) begin
            s_next.rd_en = 1'b1;
            s_next.st    = LNK_RD;
          end else begin
            s_next.wr_en = 1'b1;
            s_next.wdata = fixed;
            s_next.st    = LNK_WR;
            if (pwdata[14:8] == `TXC_OFS_CAL) begin
              s_next.cal_shadow = fixed;
            end
            if (pwdata[14:8] == `TXC_OFS_MODEM) begin
              s_next.modem_shadow = fixed;
            end
          end
        end else if (s_reg.clr_pending) begin
          // start bit back to 0 so the next launch sees a rising edge
          s_next.addr        = `TXC_OFS_CAL;
          s_next.wdata       = s_reg.cal_shadow & 8'h7f;
          s_next.cal_shadow  = s_reg.cal_shadow & 8'h7f;
          s_next.wr_en       = 1'b1;
          s_next.st          = LNK_WR;
          s_next.clr_pending = 1'b0;
        end
      end
      LNK_WR: begin
        s_next.st              = LNK_IDLE;
        sts_set[`TXC_IRQ_XFER] = 1'b1;
      end
      LNK_RD: begin
        if (lnk.rd_valid) begin
          s_next.rd_last         = lnk.rdata;
          s_next.st              = LNK_IDLE;
          sts_set[`TXC_IRQ_XFER] = 1'b1;
        end
      end
      default: begin
        s_next.st = LNK_IDLE;
      end
    endcase

    if (apb_wr && paddr == `TXC_HOST_MASK) begin
      s_next.irq_mask = pwdata[1:0];
    end
    // set wins over a write-one clear in the same cycle
    if (apb_wr && paddr == `TXC_HOST_IRQ) begin
      s_next.irq_sts = s_reg.irq_sts & ~pwdata[1:0];
    end
    s_next.irq_sts = s_next.irq_sts | sts_set;
    s_next.irq     = |(s_next.irq_sts & s_next.irq_mask);

    // no wait state: answer registered from the setup cycle
    s_next.pready  = psel & ~penable;
    s_next.pslverr = 1'b0;
    s_next.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        `TXC_HOST_CMD:  s_next.prdata = 32'h0000_0000;
        `TXC_HOST_STAT: s_next.prdata = {16'h0000, s_reg.rd_last, 5'h00,
                                         lnk.cal_complete, s_reg.clr_pending,
                                         s_reg.st != LNK_IDLE};
        `TXC_HOST_IRQ:  s_next.prdata = {30'h0000_0000, s_reg.irq_sts};
        `TXC_HOST_MASK: s_next.prdata = {30'h0000_0000, s_reg.irq_mask};
        default:        s_next.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{
        st:           LNK_IDLE,
        wr_en:        1'b0,
        rd_en:        1'b0,
        addr:         7'h00,
        wdata:        8'h00,
        rd_last:      8'h00,
        cal_shadow:   `TXC_RST_CAL,
        modem_shadow: `TXC_RST_MODEM,
        clr_pending:  1'b0,
        done_seen:    1'b0,
        irq_sts:      2'b00,
        irq_mask:     2'b00,
        irq:          1'b0,
        prdata:       32'h0000_0000,
        pready:       1'b0,
        pslverr:      1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.wr_en = s_reg.wr_en;
  assign lnk.rd_en = s_reg.rd_en;
  assign lnk.addr  = s_reg.addr;
  assign lnk.wdata = s_reg.wdata;
  assign prdata    = s_reg.prdata;
  assign pready    = s_reg.pready;
  assign pslverr   = s_reg.pslverr;
  assign irq       = s_reg.irq;
endmodule // txc_host

// >>> tb/txc_properties.sv
`timescale 1ns/1ns
`include "txc_consts.svh"
module txc_properties (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rd_valid,
  input wire logic       cal_complete
);
  logic [7:0] cal_q;
  logic [7:0] modem_q;
  logic [7:0] synth_q;
  logic [7:0] divf_q;
  logic [6:0] raddr_q;
  logic       launch;
  // shadow of what the link wrote; modem_q, synth_q and divf_q masked as the device stores them
  assign launch = wr_en && addr == `TXC_OFS_CAL && wdata[7] && !cal_q[7];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_q   <= `TXC_RST_CAL;
      modem_q <= `TXC_RST_MODEM;
      synth_q <= `TXC_RST_SYNTH;
      divf_q  <= `TXC_RST_DIVF;
      raddr_q <= 7'h00;
    end else begin
      if (rd_en) raddr_q <= addr;
      if (wr_en && addr == `TXC_OFS_CAL) cal_q <= wdata;
      if (wr_en && addr == `TXC_OFS_MODEM) modem_q <= wdata & `TXC_MASK_MODEM;
      if (wr_en && addr == `TXC_OFS_SYNTH) synth_q <= wdata & `TXC_MASK_SYNTH;
      if (wr_en && addr == `TXC_OFS_DIVF) divf_q <= wdata & `TXC_MASK_DIVF;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RD_ANSWER: assert property (rd_en |=> rd_valid ##1 !rd_valid)
    else $error("read answer missing or long");
  AST_DONE_RESET: assert property ($rose(arst_n) |-> !cal_complete)
    else $error("done set after reset");
  AST_DONE_CLEAR: assert property (launch |=> !cal_complete)
    else $error("done not cleared by launch");
  AST_DONE_HOLD: assert property (cal_complete && !launch |=> cal_complete)
    else $error("done dropped without launch");
  // at least half the wait in ticks, a tick per cycle at most
  AST_DONE_NOT_EARLY: assert property (launch |=> !cal_complete [*3])
    else $error("calibration ended too soon");
  AST_CAL_READ: assert property (rd_valid && raddr_q == `TXC_OFS_CAL |->
    {rdata[7:4], rdata[2:0]} == {cal_q[7:4], cal_q[2:0]})
    else $error("cal readback wrong");
  AST_MODEM_READ: assert property (rd_valid && raddr_q == `TXC_OFS_MODEM |->
    rdata == modem_q)
    else $error("modem readback wrong");
  AST_SYNTH_READ: assert property (rd_valid && raddr_q == `TXC_OFS_SYNTH |->
    rdata == synth_q)
    else $error("synth readback wrong");
  AST_DIVF_READ: assert property (rd_valid && raddr_q == `TXC_OFS_DIVF |->
    rdata == divf_q)
    else $error("divider readback wrong");
endmodule // txc_properties

// >>> tb/test_tx_calib_modem_config_regs.sv
`timescale 1ns/1ns
`include "txc_consts.svh"
module test_tx_calib_modem_config_regs;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ref_tick, slot_b_select, synth_hold_low, loop_r_bypass, loop_c_disconnect;
  logic        cal_active, cal_current_double, cal_store_a, cal_store_b;
  logic [2:0]  symbol_rate_select, calib_dac_start_value;
  logic [9:0]  symbol_rate_hbaud;
  logic [1:0]  line_coding, crystal_range_select, pre_swing, pre_current;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n_a = 0;
  int          n_b = 0;
  int          n_dbl = 0;
  txc_if lnk ();
  txc_device #(.CAL_WAIT_TICKS(8)) txc_device_i (.clk(clk), .arst_n(arst_n), .lnk(lnk),
    .ref_tick(ref_tick), .slot_b_select(slot_b_select),
    .symbol_rate_select(symbol_rate_select), .symbol_rate_hbaud(symbol_rate_hbaud),
    .line_coding(line_coding), .crystal_range_select(crystal_range_select),
    .synth_hold_low(synth_hold_low), .pre_swing(pre_swing), .pre_current(pre_current),
    .loop_r_bypass(loop_r_bypass), .loop_c_disconnect(loop_c_disconnect),
    .calib_dac_start_value(calib_dac_start_value), .cal_active(cal_active),
    .cal_current_double(cal_current_double), .cal_store_a(cal_store_a),
    .cal_store_b(cal_store_b));
  txc_host txc_host_i (.clk(clk), .arst_n(arst_n), .lnk(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  txc_properties txc_properties_i (.clk(clk), .arst_n(arst_n), .wr_en(lnk.wr_en),
    .rd_en(lnk.rd_en), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .rd_valid(lnk.rd_valid), .cal_complete(lnk.cal_complete));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cal_store_a === 1'b1) n_a++;
    if (cal_store_b === 1'b1) n_b++;
    if (cal_current_double === 1'b1) n_dbl++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    do apb(1'b0, `TXC_HOST_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
    apb(1'b1, `TXC_HOST_CMD, {15'h0000, 1'b0, 1'b0, a, d});
    wait_idle();
  endtask
  task automatic dev_rd(input logic [6:0] a);
    apb(1'b1, `TXC_HOST_CMD, {15'h0000, 1'b1, 1'b0, a, 8'h00});
    wait_idle();
  endtask
  task automatic tick;
    @(posedge clk);
    ref_tick <= 1'b1;
    @(posedge clk);
    ref_tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset;
    dev_rd(`TXC_OFS_CAL);
    check(rd[15:8], 8'h05);
    dev_rd(`TXC_OFS_MODEM);
    check(rd[15:8], 8'h24);
    dev_rd(`TXC_OFS_SYNTH);
    check(rd[15:8], 8'h01);
    dev_rd(`TXC_OFS_DIVF);
    check(rd[15:8], 8'h00);
    check({symbol_rate_hbaud, line_coding, synth_hold_low}, {10'h018, 2'h1, 1'b1});
  endtask
  task automatic t_modem;
    int hb[8];
    hb = '{6, 12, 24, 48, 96, 192, 384, 768};
    for (int i = 0; i < 8; i++) begin
      // crystal bits come back as the host's fixed range, not as written
      dev_wr(`TXC_OFS_MODEM, {1'b0, i[2:0], i[1:0], 2'h3});
      check(symbol_rate_hbaud, hb[i]);
      check(symbol_rate_select, i[2:0]);
      check(line_coding, i[1:0]);
      check(crystal_range_select, 2'h0);
    end
  endtask
  task automatic t_divf;
    dev_wr(`TXC_OFS_DIVF, 8'hfc);
    check({pre_swing, pre_current, loop_r_bypass, loop_c_disconnect}, 6'h3f);
    dev_wr(`TXC_OFS_DIVF, 8'h47);
    check({pre_swing, pre_current, loop_r_bypass, loop_c_disconnect}, 6'h11);
    dev_rd(`TXC_OFS_DIVF);
    check(rd[15:8], 8'h44);
    dev_wr(`TXC_OFS_MODEM, 8'h24);
    dev_wr(`TXC_OFS_DIVF, 8'h0c);
    check({loop_r_bypass, loop_c_disconnect}, 2'h2);
    dev_wr(`TXC_OFS_SYNTH, 8'hfe);
    check(synth_hold_low, 1'b0);
    dev_wr(`TXC_OFS_SYNTH, 8'h01);
    check(synth_hold_low, 1'b1);
    dev_rd(7'h20);
    check(rd[15:8], 8'h00);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(err, 1'b1);
  endtask
  task automatic t_cal(input logic dual, full, curr, slotb, irq_exp);
    int a0, b0, d0;
    slot_b_select <= slotb;
    a0 = n_a;
    b0 = n_b;
    d0 = n_dbl;
    dev_wr(`TXC_OFS_CAL, {1'b1, dual, full, curr, 4'h0});
    check({cal_active, lnk.cal_complete}, 2'h2);
    check(calib_dac_start_value, 3'h6);
    repeat (full ? 7 : 3) tick();
    repeat (4) @(posedge clk);
    check(cal_active, 1'b1);
    tick();
    repeat (6) @(posedge clk);
    check({cal_active, lnk.cal_complete}, 2'h1);
    check(n_a - a0, dual | !slotb);
    check(n_b - b0, dual | slotb);
    check(n_dbl > d0, curr);
    check(irq, irq_exp);
    // the event latches whether or not it is masked in
    apb(1'b0, `TXC_HOST_IRQ, 32'h0000_0000);
    check(rd[1:0], 2'h3);
    apb(1'b0, `TXC_HOST_MASK, 32'h0000_0000);
    check(rd[1:0], {irq_exp, 1'b0});
    apb(1'b1, `TXC_HOST_IRQ, 32'h0000_0003);
    // irq is launched by the clearing edge itself; look one edge later
    @(posedge clk);
    check(irq, 1'b0);
    wait_idle();
    dev_rd(`TXC_OFS_CAL);
    check(rd[15:8], {1'b0, dual, full, curr, 1'b1, 3'h6});
    check(rd[2], 1'b1);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ref_tick = 1'b0;
    slot_b_select = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_modem();
    t_divf();
    apb(1'b1, `TXC_HOST_MASK, 32'h0000_0002);
    t_cal(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    t_cal(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    // masked out: the event still latches but the line stays low
    apb(1'b1, `TXC_HOST_MASK, 32'h0000_0000);
    t_cal(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // test_tx_calib_modem_config_regs
